// [verilog/ddr3_bus_capture_demux.sv]
// passive ddr3 bus capture, section demultiplex, qualifier and mode decode
`include "ddr3_capture_defines.svh"
module ddr3_bus_capture_demux (
  // system side
  input  wire logic                    clk_sys,
  input  wire logic                    rst_n,
  // bus probe, all inputs only
  input  wire logic                    reference_bus_clock,
  input  wire logic [1:0]              cke,
  input  wire logic [3:0]              cs_n,
  input  wire logic                    ras_n,
  input  wire logic                    cas_n,
  input  wire logic                    we_n,
  input  wire logic [2:0]              ba,
  input  wire logic [15:0]             addr,
  input  wire logic [`GRP_W-1:0]       rd_dq,
  input  wire logic [`GRP_W-1:0]       wr_dq,
  // configuration, static while running
  input  wire logic                    mode_4x,
  input  wire logic                    keep_mode_set_only,
  input  wire logic [15:0]             addr_invert,
  input  wire logic [1:0]              grp_pt_ac,
  input  wire logic [1:0]              grp_pt_bd,
  input  wire logic [15:0]             bit_pt_ovr,
  input  wire logic [15:0]             bit_pt_ac,
  input  wire logic [15:0]             bit_pt_bd,
  // acquisition control and readout
  input  wire logic                    acq_run,
  input  wire logic [`PTR_W-1:0]       rd_idx,
  output logic [`REC_W-1:0]            rd_data_reg,
  output logic [`PTR_W-1:0]            wr_ptr_reg,
  output logic [`CNT_W-1:0]            rec_count_reg,
  output logic                         rec_stored_reg,
  // decoded mode register state
  output logic                         mr0_valid_reg,
  output logic [3:0]                   cas_code_reg,
  output logic [1:0]                   burst_code_reg,
  output logic                         decode_err_reg,
  output logic [3:0]                   decode_err_bit_reg
);

  // ************************************************
  // decode functions
  // ************************************************
  // select qualification with matching clock enable
  function automatic logic sel_ok(input logic [`CMD_W-1:0] c);
    logic [3:0] s;
    logic [1:0] e;
    s = c[`CMD_CS_LSB +: 4];
    e = c[`CMD_CKE_LSB +: 2];
    case (s)
      `CS_RANK0: sel_ok = e[0];
      `CS_RANK1: sel_ok = e[1];
      `CS_RANK2: sel_ok = e[0];
      `CS_RANK3: sel_ok = e[1];
      default:   sel_ok = 1'b0;
    endcase
  endfunction

  // row, column, write strobes all low; address is don't-care
  function automatic logic is_mode_set(input logic [`CMD_W-1:0] c);
    is_mode_set = sel_ok(c) & ~c[`CMD_RAS] & ~c[`CMD_CAS] & ~c[`CMD_WE];
  endfunction

  function automatic logic is_rank0_set(input logic [`CMD_W-1:0] c);
    is_rank0_set = is_mode_set(c) & (c[`CMD_CS_LSB +: 4] == `CS_RANK0);
  endfunction

  // highest offending address bit
  function automatic logic [3:0] hi_bit(input logic [15:0] v);
    hi_bit = 4'h0;
    for (int i = 0; i < 16; i++) begin
      if (v[i]) begin
        hi_bit = 4'(i);
      end
    end
  endfunction

  // ************************************************
  // link domain reset and configuration crossing
  // ************************************************
  logic lrst_meta_reg;
  logic lrst_n_reg;
  always_ff @(posedge reference_bus_clock or negedge rst_n) begin
    if (!rst_n) begin
      lrst_meta_reg <= 1'b0;
      lrst_n_reg    <= 1'b0;
    end else begin
      lrst_meta_reg <= 1'b1;
      lrst_n_reg    <= lrst_meta_reg;
    end
  end

  // config is static during a run, so a plain two-stage sync per bit is enough
  wire  [`CFG_W-1:0] cfg_in = {mode_4x, keep_mode_set_only, addr_invert, grp_pt_ac,
                               grp_pt_bd, bit_pt_ovr, bit_pt_ac, bit_pt_bd};
  logic [`CFG_W-1:0] cfg_meta_reg;
  logic [`CFG_W-1:0] cfg_reg;
  always_ff @(posedge reference_bus_clock or negedge lrst_n_reg) begin
    if (!lrst_n_reg) begin
      cfg_meta_reg <= '0;
      cfg_reg      <= '0;
    end else begin
      cfg_meta_reg <= cfg_in;
      cfg_reg      <= cfg_meta_reg;
    end
  end

  wire        l_mode_4x   = cfg_reg[69];
  wire        l_keep_only = cfg_reg[68];
  wire [15:0] l_inv       = cfg_reg[67:52];
  wire [1:0]  l_grp_ac    = cfg_reg[51:50];
  wire [1:0]  l_grp_bd    = cfg_reg[49:48];
  wire [15:0] l_ovr       = cfg_reg[47:32];
  wire [15:0] l_bit_ac    = cfg_reg[31:16];
  wire [15:0] l_bit_bd    = cfg_reg[15:0];

  // ************************************************
  // pin sampling on the reference clock
  // ************************************************
  // strobes are not probed: their timing says nothing about command or address
  logic [`CMD_W-1:0] cmd_pin_reg;
  logic [15:0]       dq_r_reg;
  logic [15:0]       dq_f_reg;
  always_ff @(posedge reference_bus_clock or negedge lrst_n_reg) begin
    if (!lrst_n_reg) begin
      cmd_pin_reg <= '0;
      dq_r_reg    <= '0;
    end else begin
      cmd_pin_reg <= {cke, cs_n, ras_n, cas_n, we_n, ba, addr ^ l_inv};
      dq_r_reg    <= {wr_dq, rd_dq};
    end
  end

  // second sample per clock, half a period after the rising one
  always_ff @(negedge reference_bus_clock or negedge lrst_n_reg) begin
    if (!lrst_n_reg) begin
      dq_f_reg <= '0;
    end else begin
      dq_f_reg <= {wr_dq, rd_dq};
    end
  end

  // ************************************************
  // sample point selection per bit
  // ************************************************
  wire [15:0] slot_ac;
  wire [15:0] slot_bd;
  generate
    for (genvar i = 0; i < 16; i++) begin : g_pt
      wire eff_ac = l_ovr[i] ? l_bit_ac[i] : l_grp_ac[i/8];
      wire eff_bd = l_ovr[i] ? l_bit_bd[i] : l_grp_bd[i/8];
      assign slot_ac[i] = eff_ac ? dq_f_reg[i] : dq_r_reg[i];
      assign slot_bd[i] = eff_bd ? dq_r_reg[i] : dq_f_reg[i];
    end
  endgenerate

  // ************************************************
  // pairing of two bus clocks into one record
  // ************************************************
  ddr3_capture_pkg::pair_phase_t phase_reg;
  logic [`CMD_W-1:0] cmd0_reg;
  logic [15:0]       ac0_reg;
  logic [15:0]       bd0_reg;
  logic [`REC_W-1:0] rec_reg;
  logic              tog_reg;

  wire [15:0] bd0_sec = l_mode_4x ? bd0_reg : 16'h0000;
  wire [15:0] bd1_sec = l_mode_4x ? slot_bd : 16'h0000;
  // sections: own, prime, partner, partner prime; two-section mode leaves primes clear
  wire [31:0] rd_secs = {bd1_sec[7:0], slot_ac[7:0], bd0_sec[7:0], ac0_reg[7:0]};
  wire [31:0] wr_secs = {bd1_sec[15:8], slot_ac[15:8], bd0_sec[15:8], ac0_reg[15:8]};
  wire [`REC_W-1:0] rec_next = {cmd_pin_reg, cmd0_reg, rd_secs, wr_secs};
  wire keep = ~l_keep_only | is_mode_set(cmd0_reg) | is_mode_set(cmd_pin_reg);

  always_ff @(posedge reference_bus_clock or negedge lrst_n_reg) begin
    if (!lrst_n_reg) begin
      phase_reg <= ddr3_capture_pkg::PH_FIRST;
    end else begin
      case (phase_reg)
        ddr3_capture_pkg::PH_FIRST:  phase_reg <= ddr3_capture_pkg::PH_SECOND;
        ddr3_capture_pkg::PH_SECOND: phase_reg <= ddr3_capture_pkg::PH_FIRST;
        default:                     phase_reg <= ddr3_capture_pkg::PH_FIRST;
      endcase
    end
  end

  wire first_clk  = (phase_reg == ddr3_capture_pkg::PH_FIRST);
  wire second_clk = (phase_reg == ddr3_capture_pkg::PH_SECOND);

  always_ff @(posedge reference_bus_clock or negedge lrst_n_reg) begin
    if (!lrst_n_reg) begin
      cmd0_reg <= '0;
      ac0_reg  <= '0;
      bd0_reg  <= '0;
    end else if (first_clk) begin
      cmd0_reg <= cmd_pin_reg;
      ac0_reg  <= slot_ac;
      bd0_reg  <= slot_bd;
    end
  end

  // one record per two bus clocks; held until the next, so the word crossing is safe
  always_ff @(posedge reference_bus_clock or negedge lrst_n_reg) begin
    if (!lrst_n_reg) begin
      rec_reg <= '0;
      tog_reg <= 1'b0;
    end else if (second_clk && keep) begin
      rec_reg <= rec_next;
      tog_reg <= ~tog_reg;
    end
  end

  // ************************************************
  // system domain record crossing
  // ************************************************
  logic tog_meta_reg;
  logic tog_sync_reg;
  logic tog_prev_reg;
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      tog_meta_reg <= 1'b0;
      tog_sync_reg <= 1'b0;
      tog_prev_reg <= 1'b0;
    end else begin
      tog_meta_reg <= tog_reg;
      tog_sync_reg <= tog_meta_reg;
      tog_prev_reg <= tog_sync_reg;
    end
  end

  wire new_rec = tog_sync_reg ^ tog_prev_reg;
  wire accept  = new_rec & acq_run;

  // ************************************************
  // circular record memory
  // ************************************************
  // wraps without stopping, so the newest records always survive
  logic [`REC_W-1:0] mem_reg [`REC_DEPTH];
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < `REC_DEPTH; i++) begin
        mem_reg[i] <= '0;
      end
    end else if (accept) begin
      mem_reg[wr_ptr_reg] <= rec_reg;
    end
  end

  wire count_full = (rec_count_reg == `CNT_W'(`REC_DEPTH));
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr_reg     <= '0;
      rec_count_reg  <= '0;
      rec_stored_reg <= 1'b0;
      rd_data_reg    <= '0;
    end else begin
      rec_stored_reg <= accept;
      rd_data_reg    <= mem_reg[rd_idx];
      if (accept) begin
        wr_ptr_reg <= wr_ptr_reg + `PTR_W'(1);
        if (!count_full) begin
          rec_count_reg <= rec_count_reg + `CNT_W'(1);
        end
      end
    end
  end

  // ************************************************
  // mode register decode from kept records
  // ************************************************
  wire [`CMD_W-1:0] rcmd0  = rec_reg[`REC_CMD0_LSB +: `CMD_W];
  wire [`CMD_W-1:0] rcmd1  = rec_reg[`REC_CMD1_LSB +: `CMD_W];
  wire              r0_hit = is_rank0_set(rcmd0) | is_rank0_set(rcmd1);
  // the later half wins, it is the newer command
  wire [`CMD_W-1:0] dcmd   = is_rank0_set(rcmd1) ? rcmd1 : rcmd0;
  wire [15:0]       daddr  = dcmd[`CMD_ADDR_LSB +: 16];
  wire [2:0]        dba    = dcmd[`CMD_BA_LSB +: 3];
  wire [15:0]       bad    = daddr & `ADDR_LOW_REQ;
  wire              is_mr0 = (dba == `BA_MR0);

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      mr0_valid_reg  <= 1'b0;
      cas_code_reg   <= `CAS_RST;
      burst_code_reg <= `BURST_RST;
    end else if (accept && r0_hit && is_mr0) begin
      mr0_valid_reg  <= 1'b1;
      cas_code_reg   <= {daddr[6], daddr[5], daddr[4], daddr[2]};
      burst_code_reg <= daddr[1:0];
    end
  end

  // error shows the state of the latest rank zero mode register set
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      decode_err_reg     <= 1'b0;
      decode_err_bit_reg <= 4'h0;
    end else if (accept && r0_hit) begin
      decode_err_reg     <= |bad;
      decode_err_bit_reg <= hi_bit(bad);
    end
  end

endmodule

// [verilog/ddr3_capture_defines.svh]
// constants for the ddr3 bus capture and demultiplex block
// Behaviour
// - one bus clock samples data, address and command; byte strobes unused
// - each probed 8-bit group fans out into two or four sections
// - four-way mode fills own, prime, partner and partner prime sections
// - two-section mode samples on the edge picked by the ac setting; first section older, second newer
// - sample point set per data group, overridable per individual bit
// - four-card mode samples both edges but stores once per two clocks
// - each four-way record holds four read and four write samples, two per clock
// - first and third slots share one setting, second and fourth another
// - qualifier can keep only mode register set commands on any select
// - capture runs until stopped; memory keeps the newest kept records
// - latency and burst come from the last captured rank zero MR0 mode register set
// - wrong-state address bit in a rank zero mode register set raises a named error
// - per-address-bit polarity inversion applied before decoding
// - latency and burst decode uses rank zero commands only
// - mode register set is select low with row, column, write strobes low
// - selects active low with matching clock enable high; rank zero is 1110
// - record half zero holds first clock, half one the second
`ifndef DDR3_CAPTURE_DEFINES_SVH
`define DDR3_CAPTURE_DEFINES_SVH
`define GRP_W        8
`define CMD_W        28
`define REC_W        120
`define REC_DEPTH    8
`define PTR_W        3
`define CNT_W        4
`define CFG_W        70
`define CMD_ADDR_LSB 0
`define CMD_BA_LSB   16
`define CMD_WE       19
`define CMD_CAS      20
`define CMD_RAS      21
`define CMD_CS_LSB   22
`define CMD_CKE_LSB  26
`define REC_WR_LSB   0
`define REC_RD_LSB   32
`define REC_CMD0_LSB 64
`define REC_CMD1_LSB 92
`define CS_RANK0     4'he
`define CS_RANK1     4'hd
`define CS_RANK2     4'hb
`define CS_RANK3     4'h7
`define BA_MR0       3'h0
`define ADDR_LOW_REQ 16'he000
`define CAS_RST      4'h0
`define BURST_RST    2'h0
`endif

// [verilog/ddr3_capture_pkg.sv]
// types shared by the ddr3 bus capture block
package ddr3_capture_pkg;
  typedef enum logic {
    PH_FIRST  = 1'b0,
    PH_SECOND = 1'b1
  } pair_phase_t;
endpackage

// [test/ddr3_capture_checker.sv]
// concurrent checks on the capture block's store and decode ports
module ddr3_capture_checker (
  // clock and reset
  input wire logic       clk_sys,
  input wire logic       rst_n,
  // watched ports
  input wire logic       acq_run,
  input wire logic       rec_stored_reg,
  input wire logic [2:0] wr_ptr_reg,
  input wire logic [3:0] rec_count_reg,
  input wire logic       mr0_valid_reg,
  input wire logic [3:0] cas_code_reg,
  input wire logic [1:0] burst_code_reg,
  input wire logic       decode_err_reg,
  input wire logic [3:0] decode_err_bit_reg
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  // ************
  // assertions
  // ************
  store_spacing_a: assert property (rec_stored_reg |=> !rec_stored_reg [*5])
    else $error("store pulses closer than two bus clocks");
  count_step_a: assert property ($changed(rec_count_reg) |-> rec_count_reg == $past(rec_count_reg) + 4'h1
    && rec_stored_reg) else $error("record count step wrong");
  ptr_step_a: assert property ($changed(wr_ptr_reg) |-> wr_ptr_reg == $past(wr_ptr_reg) + 3'h1
    && rec_stored_reg) else $error("write pointer step wrong");
  ptr_fill_a: assert property (rec_count_reg < 4'h8 |-> wr_ptr_reg == rec_count_reg[2:0])
    else $error("pointer and count disagree");
  count_cap_a: assert property (rec_count_reg <= 4'h8) else $error("record count above depth");
  idle_drop_a: assert property (!acq_run [*4] |=> !rec_stored_reg) else $error("record stored while stopped");
  valid_hold_a: assert property (mr0_valid_reg |=> mr0_valid_reg) else $error("mode seen flag dropped");
  decode_write_a: assert property ($changed(cas_code_reg) || $changed(burst_code_reg) |-> mr0_valid_reg
    && rec_stored_reg) else $error("decode moved without a record");
  err_write_a: assert property ($changed(decode_err_reg) |-> rec_stored_reg)
    else $error("decode error moved without a record");
  err_bit_a: assert property (decode_err_reg |-> decode_err_bit_reg >= 4'hd)
    else $error("decode error names a legal bit");
endmodule

// [test/ddr3_ctrl_model.sv]
// behavioural ddr3 controller that drives the probed dimm bus
module ddr3_ctrl_model (
  // bus clock and command
  output logic        reference_bus_clock,
  output logic [1:0]  cke,
  output logic [3:0]  cs_n,
  output logic        ras_n,
  output logic        cas_n,
  output logic        we_n,
  output logic [2:0]  ba,
  output logic [15:0] addr,
  // data groups
  output logic [7:0]  rd_dq,
  output logic [7:0]  wr_dq
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    {cke, cs_n, ras_n, cas_n, we_n, ba, addr} = {2'h3, 4'hf, 3'h7, 3'h0, 16'h0};
    {rd_dq, wr_dq} = 16'h5a3c;
    reference_bus_clock = 1'b0;
    #7;
    forever #40 reference_bus_clock = ~reference_bus_clock;
  end
  // rising and falling data differ so a misplaced slot shows
  always @(posedge reference_bus_clock) #5 {rd_dq, wr_dq} = 16'ha5c3;
  always @(negedge reference_bus_clock) #5 {rd_dq, wr_dq} = 16'h5a3c;
  // one command cycle, then deselect with stale lines flipped
  task automatic issue(input logic [3:0] s, input logic [1:0] c, input logic [2:0] rcw, input logic [2:0] b,
                       input logic [15:0] a);
    @(negedge reference_bus_clock);
    #5;
    {cke, cs_n, ras_n, cas_n, we_n, ba, addr} = {c, s, rcw, b, a};
    @(negedge reference_bus_clock);
    #5;
    {cke, cs_n, ras_n, cas_n, we_n, ba, addr} = {2'h3, 4'hf, 3'h7, ~b, ~a};
  endtask
endmodule

// [test/ddr3_bus_capture_demux_tb.sv]
// self-checking bench for the ddr3 bus capture block
module ddr3_bus_capture_demux_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic         clk_sys, rst_n, reference_bus_clock, ras_n, cas_n, we_n, mode_4x, keep_mode_set_only;
  logic         acq_run, rec_stored_reg, mr0_valid_reg, decode_err_reg, e_valid, e_err;
  logic [1:0]   cke, grp_pt_ac, grp_pt_bd, burst_code_reg, e_burst;
  logic [3:0]   cs_n, cas_code_reg, decode_err_bit_reg, rec_count_reg, e_cas, e_bit;
  logic [2:0]   ba, rd_idx, wr_ptr_reg;
  logic [7:0]   rd_dq, wr_dq;
  logic [15:0]  addr, addr_invert, bit_pt_ovr, bit_pt_ac, bit_pt_bd;
  logic [119:0] rd_data_reg;
  int           miscompares, checks_done, n;
  ddr3_ctrl_model u_bus (.reference_bus_clock, .cke, .cs_n, .ras_n, .cas_n, .we_n, .ba, .addr, .rd_dq, .wr_dq);
  ddr3_bus_capture_demux u_dut (.clk_sys, .rst_n, .reference_bus_clock, .cke, .cs_n, .ras_n, .cas_n, .we_n, .ba,
    .addr, .rd_dq, .wr_dq, .mode_4x, .keep_mode_set_only, .addr_invert, .grp_pt_ac, .grp_pt_bd, .bit_pt_ovr,
    .bit_pt_ac, .bit_pt_bd, .acq_run, .rd_idx, .rd_data_reg, .wr_ptr_reg, .rec_count_reg, .rec_stored_reg,
    .mr0_valid_reg, .cas_code_reg, .burst_code_reg, .decode_err_reg, .decode_err_bit_reg);
  always #12.5 clk_sys = ~clk_sys;
  // ********
  // tasks
  // ********
  task automatic chk(input string what, input logic [119:0] exp, input logic [119:0] got);
    checks_done++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // config is static while running, so give the sync time to settle
  task automatic cfg(input logic m4, input logic kp, input logic [15:0] inv, input logic [1:0] ac,
                     input logic [1:0] bd, input logic [15:0] ovr);
    @(posedge clk_sys);
    #2;
    {mode_4x, keep_mode_set_only, addr_invert, grp_pt_ac, grp_pt_bd, bit_pt_ovr} = {m4, kp, inv, ac, bd, ovr};
    repeat (40) @(posedge clk_sys);
  endtask
  function automatic logic [31:0] sec(input int g, input logic [7:0] r, input logic [7:0] f);
    logic [7:0] o, pa, pb, s1;
    o = bit_pt_ovr[8*g+:8];
    pa = (o & bit_pt_ac[8*g+:8]) | (~o & {8{grp_pt_ac[g]}});
    pb = (o & bit_pt_bd[8*g+:8]) | (~o & {8{grp_pt_bd[g]}});
    s1 = mode_4x ? (pb & r) | (~pb & f) : 8'h00;
    return {s1, (pa & f) | (~pa & r), s1, (pa & f) | (~pa & r)};
  endfunction
  task automatic send(input logic [3:0] s, input logic [1:0] c, input logic [2:0] rcw, input logic [2:0] b,
                      input logic [15:0] a, input logic st);
    logic [15:0]  ai;
    logic [119:0] rec;
    ai = a ^ addr_invert;
    n = 0;
    u_bus.issue(s, c, rcw, b, a);
    while (rec_stored_reg !== 1'b1 && n < 40) begin
      @(posedge clk_sys);
      #2;
      n++;
    end
    chk("stored", st, n < 40);
    if (st) begin
      rd_idx = wr_ptr_reg - 3'h1;
      @(posedge clk_sys);
      #2;
      rec = rd_data_reg;
      if (rec[119:92] === {c, s, rcw, b, ai})
        chk("half0", 4'hf, rec[89:86]);
      else
        chk("half1", {2'h3, 4'hf, 3'h7, ~b, ~ai}, rec[119:92]);
      chk("cmd", {c, s, rcw, b, ai}, rec[119:92] === {c, s, rcw, b, ai} ? rec[119:92] : rec[91:64]);
      chk("rd", sec(0, 8'h5a, 8'ha5), rec[63:32]);
      chk("wr", sec(1, 8'h3c, 8'hc3), rec[31:0]);
      if (s == 4'he && rcw == 3'h0) begin
        if (b == 3'h0)
          {e_valid, e_cas, e_burst} = {1'b1, ai[6:4], ai[2], ai[1:0]};
        e_err = |ai[15:13];
        e_bit = ai[15] ? 4'hf : ai[14] ? 4'he : 4'hd;
      end
      chk("valid", e_valid, mr0_valid_reg);
      chk("cas", e_cas, cas_code_reg);
      chk("burst", e_burst, burst_code_reg);
      chk("err", e_err, decode_err_reg);
      if (e_err)
        chk("errbit", e_bit, decode_err_bit_reg);
    end
  endtask
  // ********
  // sequence
  // ********
  initial begin
    clk_sys = 1'b0;
    rst_n = 1'b0;
    {mode_4x, keep_mode_set_only} = 2'h3;
    {acq_run, rd_idx, addr_invert, grp_pt_ac, grp_pt_bd, bit_pt_ovr} = '0;
    {bit_pt_ac, bit_pt_bd} = 32'h0f0f3333;
    {e_valid, e_err, e_cas, e_burst, e_bit} = '0;
    repeat (12) @(posedge clk_sys);
    #2;
    rst_n = 1'b1;
    repeat (40) @(posedge clk_sys);
    #2;
    chk("count", 0, rec_count_reg);
    acq_run = 1'b1;
    send(4'he, 2'h1, 3'h0, 3'h0, 16'h0054, 1'b1);
    send(4'he, 2'h3, 3'h3, 3'h0, 16'h0054, 1'b0);
    send(4'he, 2'h2, 3'h0, 3'h0, 16'h0054, 1'b0);
    send(4'hd, 2'h2, 3'h0, 3'h0, 16'h0003, 1'b1);
    send(4'hb, 2'h1, 3'h0, 3'h0, 16'h0003, 1'b1);
    send(4'h7, 2'h2, 3'h0, 3'h0, 16'h0003, 1'b1);
    send(4'he, 2'h1, 3'h0, 3'h1, 16'h8000, 1'b1);
    cfg(1'b1, 1'b1, 16'h8000, 2'h2, 2'h1, 16'h8080);
    send(4'he, 2'h1, 3'h0, 3'h1, 16'h8000, 1'b1);
    cfg(1'b1, 1'b1, 16'h0004, 2'h0, 2'h0, 16'h0);
    send(4'he, 2'h1, 3'h0, 3'h0, 16'h4000, 1'b1);
    cfg(1'b0, 1'b1, 16'h0, 2'h1, 2'h2, 16'h0101);
    send(4'he, 2'h1, 3'h0, 3'h0, 16'h0062, 1'b1);
    acq_run = 1'b0;
    send(4'he, 2'h1, 3'h0, 3'h0, 16'h0062, 1'b0);
    acq_run = 1'b1;
    for (int i = 0; i < 4; i++)
      send(4'he, 2'h1, 3'h0, 3'h0, 16'(i * 17), 1'b1);
    chk("full", 8, rec_count_reg);
    chk("wrap", 4, wr_ptr_reg);
    cfg(1'b1, 1'b0, 16'h0, 2'h0, 2'h0, 16'h0);
    n = 0;
    repeat (256) begin
      @(posedge clk_sys);
      #2;
      n += rec_stored_reg;
    end
    chk("rate", 1, n >= 39 && n <= 41);
    end_of_test();
  end
  // the whole sequence needs about 20 us; ten times that means a hang
  initial begin
    #200us;
    miscompares++;
    end_of_test();
  end
endmodule
bind ddr3_bus_capture_demux ddr3_capture_checker u_chk (.clk_sys, .rst_n, .acq_run, .rec_stored_reg, .wr_ptr_reg,
  .rec_count_reg, .mr0_valid_reg, .cas_code_reg, .burst_code_reg, .decode_err_reg, .decode_err_bit_reg);
